// ### common/hlsb_pkg.sv
// Package for the bridge-side link session controller.
// Assumes one 10 MHz clock and a packet transport that owns the radio.
package hlsb_pkg;
    // Clock rate and transmit timeout
    localparam int CLK_MHZ = 10; // Clock rate in MHz
    localparam int TX_TIMEOUT_US = 1000; // Back-channel acknowledge timeout in us
    localparam int TX_TIMEOUT_CYC = TX_TIMEOUT_US * CLK_MHZ; // Timeout in clock cycles

    // Packet header fields
    localparam logic [3:0] TYPE_DATA = 4'h4; // Data packet type
    localparam logic [3:0] TYPE_KEY = 4'h8; // Encryption key packet type
    localparam int HDR_REQ_BIT = 3; // Lock-indicator request flag position
    localparam int HDR_TOG_BIT = 2; // Data toggle position
    localparam int HDR_HALF_BIT = 0; // Key half select position
    localparam int PAYLOAD_BYTES = 8; // Fixed payload length in bytes

    // Cipher constants
    localparam logic [31:0] TEA_DELTA = 32'h9E3779B9; // Round constant
    localparam logic [4:0] TEA_LAST = 5'h1F; // Index of the last cycle of 32

    // Register word addresses
    localparam logic [3:0] REG_CTRL = 4'h0; // Control
    localparam logic [3:0] REG_LOCK = 4'h1; // Lock-indicator data
    localparam logic [3:0] REG_STATUS = 4'h2; // Status
    localparam logic [3:0] REG_BRIDGE_ID = 4'h3; // Bridge serial identifier
    localparam logic [3:0] REG_PERIPH_ID = 4'h4; // Peripheral serial identifier
    localparam logic [3:0] REG_RX_LO = 4'h5; // Last new keyboard payload, low word
    localparam logic [3:0] REG_RX_HI = 4'h6; // Last new keyboard payload, high word
    localparam logic [3:0] REG_RX_CNT = 4'h7; // Count of new keyboard packets
    localparam logic [3:0] REG_KEY0 = 4'h8; // Key word 0, words 1 to 3 follow

    // Control bit positions and reset values
    localparam int CTRL_GEN_BIT = 0; // Write 1: generate a new key
    localparam int CTRL_BC_EN_BIT = 1; // Back channel enable
    localparam logic CTRL_BC_EN_RST = 1'b1; // Back channel enabled after reset
    localparam logic [31:0] LFSR_SEED = 32'h0000_0001; // Key source seed
    localparam logic [31:0] LFSR_TAPS = 32'h8020_0003; // Key source feedback taps

    // Packet carrier
    typedef struct packed {
        logic [7:0] hdr; // Header byte
        logic [63:0] payload; // Eight payload bytes, byte 0 in [63:56]
    } hlsb_pkt_t;

    // Controller states, one-hot
    typedef enum logic [4:0] {
        ST_RX = 5'h01, // Listening for keyboard packets
        ST_ENC = 5'h02, // Ciphering a key half
        ST_TX = 5'h04, // Handing a packet to the transport
        ST_ACK = 5'h08, // Waiting for the acknowledge
        ST_SPARE = 5'h10 // Never entered
    } hlsb_state_t;
endpackage : hlsb_pkg

// ### logic/hlsb_bridge.sv
// Bridge-side session controller: lock-indicator back channel and key sharing.
// Assumes a packet transport beside it that sends, receives and reports
// automatic acknowledges, and a software port with read data one cycle late.
// Operation
// - Bridge holds lock data until keyboard packet
// - Flagged keyboard packet makes bridge send data
// - Bridge returns to receive on ack/timeout
// - Back-channel toggle cleared on successful bind
// - Bridge inverts toggle on keyboard acknowledge of lock data
// - Back-channel toggle independent of forward toggle
// - Encrypted payloads are exactly eight bytes
// - Cipher is TEA, 128-bit key
// - Bridge generates and shares the key
// - Key request answered with ciphered half
// - Data toggle changes per new packet
// - Key packets use type eight
module hlsb_bridge #(
    parameter int P_TX_TIMEOUT_CYC = hlsb_pkg::TX_TIMEOUT_CYC // Acknowledge timeout
) (
    input wire logic i_mclk, // System clock
    input wire logic i_nrst, // Synchronous reset, active low
    input wire logic [3:0] i_addr, // Register word address
    input wire logic [31:0] i_wdata, // Register write data
    input wire logic i_wr, // Register write strobe
    input wire logic i_rd, // Register read strobe
    output logic [31:0] o_rdata, // Register read data, cycle after i_rd
    input wire logic i_rx_valid, // Received packet strobe
    input wire hlsb_pkg::hlsb_pkt_t i_rx_pkt, // Received packet
    output logic o_tx_valid, // Packet offered to transport
    output hlsb_pkg::hlsb_pkt_t o_tx_pkt, // Packet to send
    input wire logic i_tx_ready, // Transport takes the packet
    input wire logic i_auto_ack, // Automatic acknowledge received
    input wire logic i_bind_done, // Bind completed successfully
    output logic o_bc_toggle, // Back-channel toggle state
    output logic o_key_valid // Key has been generated or written
);
    // Declarations
    hlsb_pkg::hlsb_state_t state_reg; // Controller state
    hlsb_pkg::hlsb_pkt_t tx_pkt_reg; // Packet being sent
    logic kind_data_reg; // Outstanding packet is back-channel data
    logic [31:0] timer_reg; // Acknowledge wait counter
    logic [4:0] round_reg; // Cipher cycle counter
    logic [31:0] v0_reg; // Cipher left half
    logic [31:0] v1_reg; // Cipher right half
    logic [31:0] sum_reg; // Cipher running sum
    logic key_half_reg; // Key half being ciphered
    logic bc_tog_reg; // Bridge-to-keyboard toggle
    logic fw_tog_reg; // Keyboard-to-bridge toggle last seen
    logic fw_seen_reg; // A keyboard data packet has been seen
    logic bc_en_reg; // Back channel enable
    logic [7:0] lock_reg; // Lock-indicator data
    logic pending_reg; // Lock data not yet delivered
    logic [31:0] bridge_id_reg; // Bridge identifier
    logic [31:0] periph_id_reg; // Peripheral identifier
    logic [63:0] rx_data_reg; // Last new keyboard payload
    logic [31:0] rx_cnt_reg; // New keyboard packets seen
    logic [31:0] key_reg [4]; // Data encryption key, word 0 first
    logic key_valid_reg; // Key generated or written
    logic [31:0] lfsr_reg; // Free-running key source
    logic [127:0] kek; // Key-encryption key
    logic [63:0] enc_next; // One cipher cycle applied
    logic rx_data_pkt; // Received packet is keyboard data
    logic rx_key_pkt; // Received packet is a key request
    logic ack_data; // Back-channel data acknowledged
    logic tx_timeout; // Acknowledge wait expired
    logic wr_lock; // Software writes lock data

    // Packet type of a header byte
    function automatic logic [3:0] pkt_type(input logic [7:0] hdr);
        pkt_type = hdr[7:4];
    endfunction : pkt_type

    // One full TEA cycle: both Feistel halves with the updated sum
    function automatic logic [63:0] tea_cycle(input logic [63:0] v, input logic [31:0] s,
                                              input logic [127:0] k);
        logic [31:0] a;
        logic [31:0] b;
        a = v[63:32];
        b = v[31:0];
        a = a + (((b << 4) + k[127:96]) ^ (b + s) ^ ((b >> 5) + k[95:64]));
        b = b + (((a << 4) + k[63:32]) ^ (a + s) ^ ((a >> 5) + k[31:0]));
        tea_cycle = {a, b};
    endfunction : tea_cycle

    // Decodes shared by several processes
    assign rx_data_pkt = i_rx_valid && (pkt_type(i_rx_pkt.hdr) == hlsb_pkg::TYPE_DATA);
    assign rx_key_pkt = i_rx_valid && (pkt_type(i_rx_pkt.hdr) == hlsb_pkg::TYPE_KEY);
    assign ack_data = (state_reg == hlsb_pkg::ST_ACK) && i_auto_ack && kind_data_reg;
    assign tx_timeout = (timer_reg == 32'(P_TX_TIMEOUT_CYC - 1));
    assign wr_lock = i_wr && (i_addr == hlsb_pkg::REG_LOCK);
    // Key-encryption key built from both identifiers
    assign kek = {bridge_id_reg, periph_id_reg, ~bridge_id_reg, ~periph_id_reg};
    assign enc_next = tea_cycle({v0_reg, v1_reg}, sum_reg + hlsb_pkg::TEA_DELTA, kek);

    // Main sequence: listen, cipher, send, wait for acknowledge
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            state_reg <= hlsb_pkg::ST_RX;
            tx_pkt_reg <= '0;
            kind_data_reg <= 1'b0;
            key_half_reg <= 1'b0;
        end else begin
            case (state_reg)
                hlsb_pkg::ST_RX: begin
                    // Lock data leaves only in answer to a flagged data packet
                    if (rx_data_pkt && i_rx_pkt.hdr[hlsb_pkg::HDR_REQ_BIT] && bc_en_reg) begin
                        // Enter transmit with lock data and the back toggle
                        tx_pkt_reg.hdr <= {hlsb_pkg::TYPE_DATA, 1'b0, bc_tog_reg, 2'b00};
                        tx_pkt_reg.payload <= {lock_reg, 56'h0};
                        kind_data_reg <= 1'b1;
                        state_reg <= hlsb_pkg::ST_TX;
                    end else if (rx_key_pkt && key_valid_reg) begin
                        // Key request: cipher the asked half
                        key_half_reg <= i_rx_pkt.hdr[hlsb_pkg::HDR_HALF_BIT];
                        kind_data_reg <= 1'b0;
                        state_reg <= hlsb_pkg::ST_ENC;
                    end
                end
                hlsb_pkg::ST_ENC: begin
                    // Ciphered half goes out as an eight-byte key response
                    if (round_reg == hlsb_pkg::TEA_LAST) begin
                        tx_pkt_reg.hdr <= {hlsb_pkg::TYPE_KEY, 3'b000, key_half_reg};
                        tx_pkt_reg.payload <= enc_next;
                        state_reg <= hlsb_pkg::ST_TX;
                    end
                end
                hlsb_pkg::ST_TX: begin
                    // Transport has taken the packet
                    if (i_tx_ready) begin
                        state_reg <= hlsb_pkg::ST_ACK;
                    end
                end
                hlsb_pkg::ST_ACK: begin
                    // Back to receive on acknowledge or timeout
                    if (i_auto_ack || tx_timeout) begin
                        state_reg <= hlsb_pkg::ST_RX;
                    end
                end
                default: begin
                    state_reg <= hlsb_pkg::ST_RX;
                end
            endcase
        end
    end

    // Acknowledge wait timer, running only while waiting
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            timer_reg <= '0;
        end else if (state_reg == hlsb_pkg::ST_ACK) begin
            timer_reg <= timer_reg + 32'h1;
        end else begin
            timer_reg <= '0;
        end
    end

    // Cipher datapath, 32 cycles per half
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            round_reg <= '0;
            v0_reg <= '0;
            v1_reg <= '0;
            sum_reg <= '0;
        end else if (state_reg == hlsb_pkg::ST_ENC) begin
            {v0_reg, v1_reg} <= enc_next;
            sum_reg <= sum_reg + hlsb_pkg::TEA_DELTA;
            round_reg <= round_reg + 5'h1;
        end else if (state_reg == hlsb_pkg::ST_RX && rx_key_pkt) begin
            // Load the requested 64-bit half of the key
            v0_reg <= i_rx_pkt.hdr[hlsb_pkg::HDR_HALF_BIT] ? key_reg[2] : key_reg[0];
            v1_reg <= i_rx_pkt.hdr[hlsb_pkg::HDR_HALF_BIT] ? key_reg[3] : key_reg[1];
            sum_reg <= '0;
            round_reg <= '0;
        end
    end

    // Back-channel toggle: cleared by bind, inverted on acknowledge of lock data
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            bc_tog_reg <= 1'b0;
        end else if (i_bind_done) begin
            bc_tog_reg <= 1'b0;
        end else if (ack_data) begin
            bc_tog_reg <= ~bc_tog_reg;
        end
    end

    // Forward toggle kept apart from the back toggle
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            fw_tog_reg <= 1'b0;
            fw_seen_reg <= 1'b0;
            rx_data_reg <= '0;
            rx_cnt_reg <= '0;
        end else if (i_bind_done) begin
            fw_seen_reg <= 1'b0;
        end else if (state_reg == hlsb_pkg::ST_RX && rx_data_pkt) begin
            // Only a changed toggle, or the first packet since reset or bind, marks new data; repeats are dropped
            if (!fw_seen_reg || i_rx_pkt.hdr[hlsb_pkg::HDR_TOG_BIT] != fw_tog_reg) begin
                fw_tog_reg <= i_rx_pkt.hdr[hlsb_pkg::HDR_TOG_BIT];
                fw_seen_reg <= 1'b1;
                rx_data_reg <= i_rx_pkt.payload;
                rx_cnt_reg <= rx_cnt_reg + 32'h1;
            end
        end
    end

    // Pending lock data: a new write beats a same-cycle delivery
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            pending_reg <= 1'b0;
        end else if (wr_lock) begin
            pending_reg <= 1'b1;
        end else if (ack_data) begin
            pending_reg <= 1'b0;
        end
    end

    // Software-written configuration
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            bc_en_reg <= hlsb_pkg::CTRL_BC_EN_RST;
            lock_reg <= '0;
            bridge_id_reg <= '0;
            periph_id_reg <= '0;
        end else if (i_wr) begin
            case (i_addr)
                hlsb_pkg::REG_CTRL: bc_en_reg <= i_wdata[hlsb_pkg::CTRL_BC_EN_BIT];
                hlsb_pkg::REG_LOCK: lock_reg <= i_wdata[7:0];
                hlsb_pkg::REG_BRIDGE_ID: bridge_id_reg <= i_wdata;
                hlsb_pkg::REG_PERIPH_ID: periph_id_reg <= i_wdata;
                default: begin
                end
            endcase
        end
    end

    // Free-running key source
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            lfsr_reg <= hlsb_pkg::LFSR_SEED;
        end else begin
            lfsr_reg <= {lfsr_reg[30:0], ^(lfsr_reg & hlsb_pkg::LFSR_TAPS)};
        end
    end

    // Key storage: generated on command or written directly
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            for (int i = 0; i < 4; i++) begin
                key_reg[i] <= '0;
            end
            key_valid_reg <= 1'b0;
        end else if (i_wr && i_addr == hlsb_pkg::REG_CTRL && i_wdata[hlsb_pkg::CTRL_GEN_BIT]) begin
            key_reg[0] <= lfsr_reg;
            key_reg[1] <= {lfsr_reg[15:0], lfsr_reg[31:16]} ^ bridge_id_reg;
            key_reg[2] <= ~lfsr_reg ^ periph_id_reg;
            key_reg[3] <= {lfsr_reg[7:0], lfsr_reg[31:8]};
            key_valid_reg <= 1'b1;
        end else if (i_wr && i_addr[3:2] == hlsb_pkg::REG_KEY0[3:2]) begin
            key_reg[i_addr[1:0]] <= i_wdata;
            key_valid_reg <= 1'b1;
        end
    end

    // Register read, data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                hlsb_pkg::REG_CTRL: o_rdata <= {30'h0, bc_en_reg, 1'b0};
                hlsb_pkg::REG_LOCK: o_rdata <= {24'h0, lock_reg};
                hlsb_pkg::REG_STATUS: o_rdata <= {23'h0, fw_tog_reg, state_reg,
                                                  key_valid_reg, pending_reg, bc_tog_reg};
                hlsb_pkg::REG_BRIDGE_ID: o_rdata <= bridge_id_reg;
                hlsb_pkg::REG_PERIPH_ID: o_rdata <= periph_id_reg;
                hlsb_pkg::REG_RX_LO: o_rdata <= rx_data_reg[31:0];
                hlsb_pkg::REG_RX_HI: o_rdata <= rx_data_reg[63:32];
                hlsb_pkg::REG_RX_CNT: o_rdata <= rx_cnt_reg;
                4'h8, 4'h9, 4'hA, 4'hB: o_rdata <= key_reg[i_addr[1:0]];
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    // Outputs
    assign o_tx_valid = (state_reg == hlsb_pkg::ST_TX);
    assign o_tx_pkt = tx_pkt_reg;
    assign o_bc_toggle = bc_tog_reg;
    assign o_key_valid = key_valid_reg;
endmodule : hlsb_bridge

// ### verif/hlsb_bridge_sva.sv
// Port checker for the bridge controller.
// Bound onto hlsb_bridge; one clock, sync active-low reset.
module hlsb_bridge_sva #(
    parameter int P_TX_TIMEOUT_CYC = hlsb_pkg::TX_TIMEOUT_CYC // Acknowledge timeout
) (
    input wire logic i_mclk, // Clock
    input wire logic i_nrst, // Reset, active low
    input wire logic i_rd, // Read strobe
    input wire logic [31:0] o_rdata, // Read data
    input wire logic i_rx_valid, // Received packet strobe
    input wire hlsb_pkg::hlsb_pkt_t i_rx_pkt, // Received packet
    input wire logic o_tx_valid, // Packet offered
    input wire hlsb_pkg::hlsb_pkt_t o_tx_pkt, // Packet to send
    input wire logic i_tx_ready, // Transport takes it
    input wire logic i_auto_ack, // Acknowledge from keyboard
    input wire logic i_bind_done, // Bind completed
    input wire logic o_bc_toggle // Back-channel toggle
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    logic [15:0] wcnt; // Cycles spent waiting for an acknowledge, 0 when not waiting
    logic wdat; // The awaited packet carried lock data
    // Follow each wait from handshake to acknowledge, stopping short of the timeout
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            wcnt <= 16'h0000;
            wdat <= 1'b0;
        end else if (o_tx_valid && i_tx_ready) begin
            wcnt <= 16'h0001;
            wdat <= o_tx_pkt.hdr[7:4] == hlsb_pkg::TYPE_DATA;
        end else if (wcnt != 16'h0000 && !i_auto_ack && int'(wcnt) < P_TX_TIMEOUT_CYC - 1) begin
            wcnt <= wcnt + 16'h0001;
        end else begin
            wcnt <= 16'h0000;
        end
    end
    property p_bind; i_bind_done |=> !o_bc_toggle; endproperty
    a_bind: assert property (p_bind) else $error("toggle kept after bind");
    property p_hold; o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_pkt); endproperty
    a_hold: assert property (p_hold) else $error("offer dropped or changed");
    property p_src; $rose(o_tx_valid) && o_tx_pkt.hdr[7:4] == hlsb_pkg::TYPE_DATA
        |-> $past(i_rx_valid) && $past(i_rx_pkt.hdr[3]); endproperty
    a_src: assert property (p_src) else $error("lock data sent unasked");
    property p_fmt; $rose(o_tx_valid) && o_tx_pkt.hdr[7:4] == hlsb_pkg::TYPE_DATA
        |-> o_tx_pkt.hdr[3:0] == {1'b0, o_bc_toggle, 2'b00} && o_tx_pkt.payload[55:0] == 56'h0;
    endproperty
    a_fmt: assert property (p_fmt) else $error("lock packet layout wrong");
    property p_key; $rose(o_tx_valid) && o_tx_pkt.hdr[7:4] == hlsb_pkg::TYPE_KEY
        |-> $past(i_rx_valid, 33) && o_tx_pkt.hdr[3:1] == 3'h0; endproperty
    a_key: assert property (p_key) else $error("key answer late or malformed");
    property p_tchg; $changed(o_bc_toggle) |-> $past(i_auto_ack) || $past(i_bind_done); endproperty
    a_tchg: assert property (p_tchg) else $error("toggle moved without cause");
    property p_wait; wcnt != 16'h0000 |-> !o_tx_valid; endproperty
    a_wait: assert property (p_wait) else $error("sent while awaiting ack");
    property p_flip; i_auto_ack && wcnt != 16'h0000 && wdat && !i_bind_done
        |=> o_bc_toggle != $past(o_bc_toggle); endproperty
    a_flip: assert property (p_flip) else $error("toggle not inverted on ack");
    property p_rdz; !$past(i_rd) |-> o_rdata == 32'h0000_0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside its cycle");
endmodule : hlsb_bridge_sva
bind hlsb_bridge hlsb_bridge_sva #(.P_TX_TIMEOUT_CYC(P_TX_TIMEOUT_CYC)) i_sva (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(i_rx_valid),
    .i_rx_pkt(i_rx_pkt), .o_tx_valid(o_tx_valid), .o_tx_pkt(o_tx_pkt), .i_tx_ready(i_tx_ready),
    .i_auto_ack(i_auto_ack), .i_bind_done(i_bind_done), .o_bc_toggle(o_bc_toggle));

// ### verif/hlsb_kbd_model.sv
// Keyboard and transport model facing the bridge controller.
// Assumes orders from the bench arrive as one-cycle send pulses.
module hlsb_kbd_model (
    input wire logic i_mclk, i_nrst, i_bind, // Clock, reset, bind done
    input wire logic i_send, i_key, i_flag, i_resend, i_half, // Send order and its kind
    input wire logic i_no_ack, i_slow, // Withhold acknowledge, stall the transport
    input wire logic [63:0] i_payload, // Payload to send
    input wire logic i_tx_valid, // Bridge offers a packet
    input wire hlsb_pkg::hlsb_pkt_t i_tx_pkt, // Bridge packet
    output logic o_rx_valid, o_tx_ready, o_auto_ack, // To the bridge
    output hlsb_pkg::hlsb_pkt_t o_rx_pkt, // Packet to the bridge
    output logic o_tog, // Expected back-channel toggle
    output logic [7:0] o_lock, o_acc // Last accepted lock data, accept count
);
    logic fwd; // Forward toggle of the last new packet
    logic [1:0] rc; // Stall counter
    logic [2:0] ad; // Acknowledge delay
    wire take = i_tx_valid && o_tx_ready; // Handshake
    assign o_tx_ready = i_tx_valid && (!i_slow || rc == 2'h3);
    // Packet send, acknowledge and back-channel receive
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            {o_rx_valid, o_auto_ack, fwd, o_tog, rc, ad, o_lock, o_acc} <= '0;
            o_rx_pkt <= '0;
        end else begin
            o_rx_valid <= i_send;
            if (i_send && i_key) begin
                o_rx_pkt <= {hlsb_pkg::TYPE_KEY, 3'h0, i_half, i_payload};
            end else if (i_send) begin // Resend keeps the old toggle
                o_rx_pkt <= {hlsb_pkg::TYPE_DATA, i_flag, fwd ^ !i_resend, 2'h0, i_payload};
            end else begin
                o_rx_pkt <= ~o_rx_pkt; // Idle lines alternate between the last packet and its inverse
            end
            if (i_send && !i_key && !i_resend) fwd <= !fwd;
            rc <= i_tx_valid ? rc + 2'h1 : 2'h0;
            ad <= (take && !i_no_ack) ? 3'h1 : (ad != 3'h0 ? ad + 3'h1 : 3'h0);
            o_auto_ack <= ad == 3'h2;
            if (i_bind) begin
                o_tog <= 1'b0;
            end else if (take && i_tx_pkt.hdr[7:4] == hlsb_pkg::TYPE_DATA
                && i_tx_pkt.hdr[2] == o_tog) begin // Mismatch is dropped
                o_tog <= !o_tog;
                o_lock <= i_tx_pkt.payload[63:56];
                o_acc <= o_acc + 8'h01;
            end
        end
    end
endmodule : hlsb_kbd_model

// ### verif/testbench.sv
// Self-checking bench for the bridge controller.
// Assumes model and checker compile first.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TMO = 20; // Shortened acknowledge timeout
    logic i_mclk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_bind_done = 1'b0;
    logic [3:0] i_addr = 4'h0; // Register address
    logic [31:0] i_wdata = 32'h0, o_rdata, rd, bid, pid, c0, lf = 32'h0000_016A; // Bus, ids
    logic [31:0] kw [4]; // Key words
    logic send = 1'b0, key = 1'b0, flag = 1'b0, resend = 1'b0, half = 1'b0; // Model orders
    logic noack = 1'b0, slow = 1'b0, bt = 1'b0; // Model faults, expected bridge toggle
    logic [63:0] pl = 64'h0; // Keyboard payload
    logic [7:0] lk, kb_lock, kb_acc; // Lock data, keyboard view
    logic rxv, txv, txr, ack, kv, tog, kb_tog; // Link signals
    hlsb_pkg::hlsb_pkt_t rxp, txp, pk; // Packets, pk taken at handshake
    int miscompares = 0, cmp_count = 0;
    hlsb_bridge #(.P_TX_TIMEOUT_CYC(TMO)) i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(rxv),
        .i_rx_pkt(rxp), .o_tx_valid(txv), .o_tx_pkt(txp), .i_tx_ready(txr), .i_auto_ack(ack),
        .i_bind_done(i_bind_done), .o_bc_toggle(tog), .o_key_valid(kv));
    hlsb_kbd_model i_kbd (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_bind(i_bind_done), .i_send(send),
        .i_key(key), .i_flag(flag), .i_resend(resend), .i_half(half), .i_no_ack(noack),
        .i_slow(slow), .i_payload(pl), .i_tx_valid(txv), .i_tx_pkt(txp), .o_rx_valid(rxv),
        .o_tx_ready(txr), .o_auto_ack(ack), .o_rx_pkt(rxp), .o_tog(kb_tog), .o_lock(kb_lock),
        .o_acc(kb_acc));
    initial forever #50 i_mclk = ~i_mclk; // 10 MHz
    // Random source for data, ids and keys
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction : rnd
    // Reference cipher of one block
    function automatic logic [63:0] tea(input logic [63:0] v, input logic [127:0] k);
        logic [31:0] a, b, s;
        {a, b, s} = {v, 32'h0};
        for (int i = 0; i < 32; i++) begin
            s = s + hlsb_pkg::TEA_DELTA;
            a = a + (((b << 4) + k[127:96]) ^ (b + s) ^ ((b >> 5) + k[95:64]));
            b = b + (((a << 4) + k[63:32]) ^ (a + s) ^ ((a >> 5) + k[31:0]));
        end
        return {a, b};
    endfunction : tea
    // Compare and count
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Bus write and read, data taken in the cycle after the strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [3:0] a);
        @(posedge i_mclk);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        rd = o_rdata;
    endtask : rdr
    // One keyboard packet; a resend keeps the payload
    task automatic kb(input logic k, input logic f, input logic r, input logic h);
        @(posedge i_mclk);
        {key, flag, resend, half, send} <= {k, f, r, h, 1'b1};
        if (!r) pl <= {rnd(), rnd()};
        @(posedge i_mclk);
        send <= 1'b0;
    endtask : kb
    // Wait for the bridge packet handshake, bounded
    task automatic hs();
        int n;
        n = 0;
        while (!(txv === 1'b1 && txr === 1'b1) && n < 200) begin
            @(negedge i_mclk);
            n++;
        end
        pk = txp;
        if (n >= 200) chk("handshake", 64'h0, 64'h1);
    endtask : hs
    // Lock request exchange, optionally without acknowledge
    task automatic bc(input logic na, input logic r);
        lk = rnd();
        wr(hlsb_pkg::REG_LOCK, {24'h0, lk});
        noack <= na;
        rdr(hlsb_pkg::REG_STATUS);
        chk("pending", rd[1], 64'h1);
        kb(1'b0, 1'b1, r, 1'b0);
        hs();
        chk("bc_hdr", pk.hdr, {hlsb_pkg::TYPE_DATA, 1'b0, bt, 2'h0});
        chk("bc_data", pk.payload, {lk, 56'h0});
        repeat (na ? TMO + 6 : 6) @(posedge i_mclk);
        noack <= 1'b0;
        if (!na) bt = !bt;
        chk("bc_toggle", tog, bt);
    endtask : bc
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        repeat (5) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rdr(hlsb_pkg::REG_CTRL);
        chk("ctrl_reset", rd, 64'h2);
        rdr(hlsb_pkg::REG_STATUS);
        chk("status_reset", rd[7:0], 64'h08);
        rdr(4'hC);
        chk("unmapped", rd, 64'h0);
        bid = rnd();
        pid = rnd();
        wr(hlsb_pkg::REG_BRIDGE_ID, bid);
        wr(hlsb_pkg::REG_PERIPH_ID, pid);
        for (int i = 0; i < 4; i++) begin
            kw[i] = rnd();
            wr(hlsb_pkg::REG_KEY0 + 4'(i), kw[i]);
        end
        chk("key_valid", kv, 64'h1);
        for (int h = 0; h < 2; h++) begin
            kb(1'b1, 1'b0, 1'b0, 1'(h));
            hs();
            chk("key_hdr", pk.hdr, {hlsb_pkg::TYPE_KEY, 4'(h)});
            chk("key_half", pk.payload, tea({kw[2*h], kw[2*h+1]}, {bid, pid, ~bid, ~pid}));
            repeat (6) @(posedge i_mclk);
        end
        slow <= 1'b1;
        bc(1'b0, 1'b0);
        slow <= 1'b0;
        chk("kb_lock", kb_lock, lk);
        bc(1'b1, 1'b0);
        bc(1'b0, 1'b1);
        chk("kb_accepts", kb_acc, 64'h2);
        chk("kb_toggle", kb_tog, bt);
        wr(hlsb_pkg::REG_CTRL, 32'h0);
        kb(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (5) @(negedge i_mclk);
        chk("disabled", txv, 64'h0);
        wr(hlsb_pkg::REG_CTRL, 32'h2);
        rdr(hlsb_pkg::REG_RX_CNT);
        c0 = rd;
        kb(1'b0, 1'b0, 1'b0, 1'b0);
        kb(1'b0, 1'b0, 1'b1, 1'b0);
        kb(1'b0, 1'b0, 1'b0, 1'b0);
        rdr(hlsb_pkg::REG_RX_CNT);
        chk("rx_count", rd, c0 + 32'h2);
        rdr(hlsb_pkg::REG_RX_HI);
        chk("rx_hi", rd, pl[63:32]);
        bc(1'b0, 1'b0);
        @(posedge i_mclk);
        i_bind_done <= 1'b1;
        @(posedge i_mclk);
        i_bind_done <= 1'b0;
        bt = 1'b0;
        @(negedge i_mclk);
        chk("bind_clear", {tog, kb_tog}, 64'h0);
        bc(1'b0, 1'b0);
        chk("kb_after_bind", kb_acc, 64'h4);
        summarize();
    end
    // Watchdog
    initial begin
        #(100 * 20000);
        miscompares++;
        summarize();
    end
endmodule : testbench
